// *** tmr_result_regs.sv ***
// Temperature result and diode status register bank
//
// Function
// RULE1 - Internal integer byte, read only, reset zero, at 00h and 60h.
// RULE2 - Internal integer coded plain or offset binary by scale select.
// RULE3 - Internal fraction in bits 7:5, eighth-degree steps.
// RULE4 - Internal fraction at 29h and 61h, reset zero.
// RULE5 - External integer bytes at 01h,23h,2Ah,32h and mirrors 62h-68h.
// RULE6 - External integer bytes coded by the same scale select.
// RULE7 - External fraction bytes at 10h,24h,2Bh,33h and mirrors 63h-69h.
// RULE8 - Status byte at 02h with eight flags, reset zero.
// RULE9 - Status bit 7 shows external 1 or 2 rate over limit.
// RULE10 - Integer read latches fraction shadow; fraction reads return shadow.
// RULE11 - High, low or fault flag drives alert; low includes equal.
// RULE12 - Critical flags drive critical pin, clear when pin releases.
// RULE13 - Extended scale -64..191.875 offset; normal 0..127.875 plain.
// RULE14 - Unused fraction bits read zero; writes have no effect.
// RULE15 - Primary and mirror addresses share the same storage.
`timescale 1ns/100ps
module tmr_result_regs #(
  parameter int NUM_CHAN = tmr_pkg::NUM_CHAN
) (
  // Clock and reset
  input  wire logic                                      ref_clk,
  input  wire logic                                      rst,
  // Register access port
  input  wire logic [7:0]                                regAddr,
  input  wire logic                                      regRd,
  input  wire logic                                      regWr,
  input  wire logic [7:0]                                regWrData,
  output logic [7:0]                                     rdData,
  output logic                                           rdValid,
  // Scale select from configuration
  input  wire logic                                      extRange,
  // Measurement results, one strobe per channel
  input  wire logic [NUM_CHAN-1:0]                       measValid,
  input  wire logic [NUM_CHAN-1:0][tmr_pkg::RAW_W-1:0]   measTemp,
  // Status conditions
  input  wire logic                                      rocExceeded,
  input  wire logic                                      hottestChanged,
  input  wire logic                                      convBusy,
  input  wire logic                                      highEvent,
  input  wire logic                                      lowEvent,
  input  wire logic                                      faultEvent,
  input  wire logic                                      extOverCrit,
  input  wire logic                                      intOverCrit,
  // Pins, active high
  output logic                                           alertAct,
  output logic                                           critAct
);

  tmr_pkg::tmr_main_state_t         s_q;
  tmr_pkg::tmr_main_state_t         s_d;
  tmr_pkg::tmr_result_t [NUM_CHAN-1:0] enc;
  tmr_pkg::tmr_decode_t             dec;
  logic [7:0]                       statusFlags;
  logic                             statusRd;

  // Address to storage decode
  function automatic tmr_pkg::tmr_decode_t decodeAddr(
    input logic [7:0] addr
  );
    tmr_pkg::tmr_decode_t d;
    d = '0;
    if (addr == tmr_pkg::ADDR_STATUS)
    begin
      d.hit      = 1'b1;
      d.isStatus = 1'b1;
    end
    else
    begin
      for (int c = 0; c < NUM_CHAN; c++)
      begin
        // RULE15 mirror decodes alike
        if (addr == tmr_pkg::INT_OFS_PRI[c] ||
            addr == tmr_pkg::INT_OFS_MIR[c])
        begin
          d.hit  = 1'b1;
          d.chan = tmr_pkg::CHAN_IDX_W'(c);
        end
        // RULE4 RULE7 fraction addresses
        else if (addr == tmr_pkg::FRAC_OFS_PRI[c] ||
                 addr == tmr_pkg::FRAC_OFS_MIR[c])
        begin
          d.hit    = 1'b1;
          d.isFrac = 1'b1;
          d.chan   = tmr_pkg::CHAN_IDX_W'(c);
        end
      end
    end
    return d;
  endfunction : decodeAddr

  // Fraction byte with unused bits at zero
  function automatic logic [7:0] fracByte(
    input logic [tmr_pkg::FRAC_W-1:0] code
  );
    return {code, {tmr_pkg::FRAC_PAD_W{1'b0}}};
  endfunction : fracByte

  assign dec      = decodeAddr(regAddr);
  assign statusRd = regRd & dec.hit & dec.isStatus;

  // RULE2 RULE6 RULE13 scale encoding
  for (genvar c = 0; c < NUM_CHAN; c++)
  begin : g_enc
    tmr_temp_encoder u_enc (
      .tempRaw  (measTemp[c]),
      .extRange (extRange),
      .result   (enc[c])
    );
  end

  tmr_status_flags u_status (
    .ref_clk        (ref_clk),
    .rst            (rst),
    .rocExceeded    (rocExceeded),
    .hottestChanged (hottestChanged),
    .convBusy       (convBusy),
    .highEvent      (highEvent),
    .lowEvent       (lowEvent),
    .faultEvent     (faultEvent),
    .extOverCrit    (extOverCrit),
    .intOverCrit    (intOverCrit),
    .statusRd       (statusRd),
    .flags          (statusFlags),
    .alertAct       (alertAct),
    .critAct        (critAct)
  );

  always_comb
  begin
    s_d         = s_q;
    s_d.rdValid = regRd;
    s_d.rdData  = tmr_pkg::UNMAPPED;
    // Result capture from the measurement engine
    for (int c = 0; c < NUM_CHAN; c++)
    begin
      if (measValid[c])
      begin
        s_d.intB[c] = enc[c].intByte;
        s_d.frac[c] = enc[c].frac;
      end
    end
    if (regRd && dec.hit)
    begin
      if (dec.isStatus)
        // RULE8 status read
        s_d.rdData = statusFlags;
      else if (dec.isFrac)
        // RULE3 RULE7 RULE14 fraction read
        s_d.rdData = fracByte(s_q.shadow[dec.chan]);
      else
      begin
        // RULE1 RULE5 integer read
        s_d.rdData = s_q.intB[dec.chan];
        // RULE10 shadow latch
        s_d.shadow[dec.chan] = s_q.frac[dec.chan];
      end
    end
    // RULE14 writes are ignored, regWr steers nothing
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign rdData  = s_q.rdData;
  assign rdValid = s_q.rdValid;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  chk_int_primary: assert property ( // RULE1
    (regRd && regAddr == tmr_pkg::INT_OFS_PRI[0])
    |=> rdValid && rdData == $past(s_q.intB[0]))
    else $error("internal integer read wrong");
  chk_int_mirror: assert property ( // RULE15
    (regRd && regAddr == tmr_pkg::INT_OFS_MIR[0] && !measValid[0])
    ##1 (regRd && regAddr == tmr_pkg::INT_OFS_PRI[0])
    |=> rdData == $past(rdData))
    else $error("mirror and primary differ");
  chk_ext_scale: assert property ( // RULE6
    (measValid[1] && extRange && measTemp[1] == '0)
    |=> s_q.intB[1] == 8'h40 && s_q.frac[1] == tmr_pkg::RST_FRAC)
    else $error("offset binary zero wrong");
  chk_std_clamp: assert property ( // RULE13
    (measValid[0] && !extRange && measTemp[0][tmr_pkg::RAW_W-1])
    |=> s_q.intB[0] == tmr_pkg::RST_BYTE)
    else $error("negative reading not clamped");
  chk_int_scale: assert property ( // RULE2
    (measValid[0] && !extRange && measTemp[0] == 12'h0a5)
    |=> s_q.intB[0] == 8'h14 && s_q.frac[0] == 3'h5)
    else $error("plain binary coding wrong");
  chk_frac_pad: assert property ( // RULE14
    (regRd && dec.isFrac) |=> rdData[tmr_pkg::FRAC_LSB-1:0] == '0)
    else $error("unused fraction bits not zero");
  chk_frac_mirror: assert property ( // RULE4
    (regRd && regAddr == tmr_pkg::FRAC_OFS_MIR[0])
    |=> rdData == fracByte($past(s_q.shadow[0])))
    else $error("internal fraction mirror wrong");
  chk_ext_frac: assert property ( // RULE7
    (regRd && regAddr == tmr_pkg::FRAC_OFS_PRI[4])
    |=> rdData[7:tmr_pkg::FRAC_LSB] == $past(s_q.shadow[4]))
    else $error("external fraction read wrong");
  chk_ext_int: assert property ( // RULE5
    (regRd && regAddr == tmr_pkg::INT_OFS_MIR[3])
    |=> rdData == $past(s_q.intB[3]))
    else $error("external integer mirror wrong");
  chk_shadow_pair: assert property ( // RULE10
    (regRd && !dec.isFrac && !dec.isStatus && dec.hit)
    ##1 (regRd && dec.isFrac && dec.chan == $past(dec.chan))
    |=> rdData[7:tmr_pkg::FRAC_LSB] == $past(s_q.frac[dec.chan], 2))
    else $error("fraction does not match integer read");
  chk_status_read: assert property ( // RULE8
    (regRd && regAddr == tmr_pkg::ADDR_STATUS)
    |=> rdData == $past(statusFlags))
    else $error("status read wrong");
  chk_write_none: assert property ( // RULE14
    (regWr && !regRd && measValid == '0) |=> s_q.intB == $past(s_q.intB)
    && s_q.shadow == $past(s_q.shadow))
    else $error("write changed a result");
  chk_fraction_bits: assert property ( // RULE3
    (measValid[2] && !extRange && measTemp[2] == 12'h007)
    |=> s_q.frac[2] == tmr_pkg::FRAC_MAX)
    else $error("fraction code not in place");

  // Read port framing
  chk_rd_valid_set: assert property ( // RULE1
    regRd
    |=> rdValid)
    else $error("read not answered");
  chk_rd_idle: assert property ( // RULE14
    !regRd
    |=> !rdValid && rdData == tmr_pkg::UNMAPPED)
    else $error("data shown without read");
  chk_unmapped_rd: assert property ( // RULE14
    (regRd && !dec.hit)
    |=> rdData == tmr_pkg::UNMAPPED)
    else $error("unmapped read not zero");

  // Integer bytes at the other addresses
  chk_int_int_mir: assert property ( // RULE1
    (regRd && regAddr == tmr_pkg::INT_OFS_MIR[0])
    |=> rdData == $past(s_q.intB[0]))
    else $error("internal mirror wrong");
  chk_ext1_int_pri: assert property ( // RULE5
    (regRd && regAddr == tmr_pkg::INT_OFS_PRI[1])
    |=> rdData == $past(s_q.intB[1]))
    else $error("ext1 integer wrong");
  chk_ext2_int_pri: assert property ( // RULE5
    (regRd && regAddr == tmr_pkg::INT_OFS_PRI[2])
    |=> rdData == $past(s_q.intB[2]))
    else $error("ext2 integer wrong");
  chk_ext3_int_pri: assert property ( // RULE5
    (regRd && regAddr == tmr_pkg::INT_OFS_PRI[3])
    |=> rdData == $past(s_q.intB[3]))
    else $error("ext3 integer wrong");
  chk_ext4_int_pri: assert property ( // RULE5
    (regRd && regAddr == tmr_pkg::INT_OFS_PRI[4])
    |=> rdData == $past(s_q.intB[4]))
    else $error("ext4 integer wrong");

  // Fraction bytes at the other addresses
  chk_int_frac_pri: assert property ( // RULE4
    (regRd && regAddr == tmr_pkg::FRAC_OFS_PRI[0])
    |=> rdData == fracByte($past(s_q.shadow[0])))
    else $error("internal fraction wrong");
  chk_ext1_frac_mir: assert property ( // RULE7
    (regRd && regAddr == tmr_pkg::FRAC_OFS_MIR[1])
    |=> rdData == fracByte($past(s_q.shadow[1])))
    else $error("ext1 fraction wrong");
  chk_ext2_frac_mir: assert property ( // RULE7
    (regRd && regAddr == tmr_pkg::FRAC_OFS_MIR[2])
    |=> rdData == fracByte($past(s_q.shadow[2])))
    else $error("ext2 fraction wrong");
  chk_ext3_frac_mir: assert property ( // RULE7
    (regRd && regAddr == tmr_pkg::FRAC_OFS_MIR[3])
    |=> rdData == fracByte($past(s_q.shadow[3])))
    else $error("ext3 fraction wrong");
  chk_ext4_frac_mir: assert property ( // RULE7
    (regRd && regAddr == tmr_pkg::FRAC_OFS_MIR[4])
    |=> rdData == fracByte($past(s_q.shadow[4])))
    else $error("ext4 fraction wrong");
  chk_ext2_frac_pri: assert property ( // RULE7
    (regRd && regAddr == tmr_pkg::FRAC_OFS_PRI[2])
    |=> rdData == fracByte($past(s_q.shadow[2])))
    else $error("ext2 fraction primary wrong");

  // Shadow copy and held results
  chk_shadow_latch: assert property ( // RULE10
    (regRd && dec.hit && !dec.isFrac && !dec.isStatus)
    |=> s_q.shadow[$past(dec.chan)] == $past(s_q.frac[dec.chan]))
    else $error("shadow not latched");
  chk_shadow_hold: assert property ( // RULE10
    !regRd
    |=> s_q.shadow == $past(s_q.shadow))
    else $error("shadow changed without read");
  chk_result_hold: assert property ( // RULE5
    !measValid[1]
    |=> s_q.intB[1] == $past(s_q.intB[1])
    && s_q.frac[1] == $past(s_q.frac[1]))
    else $error("result changed without capture");

  // Scale limits
  chk_std_clamp_hi: assert property ( // RULE13
    (measValid[2] && !extRange && !measTemp[2][tmr_pkg::RAW_W-1]
    && measTemp[2][tmr_pkg::RAW_W-2])
    |=> s_q.intB[2] == tmr_pkg::STD_MAX[7:0]
    && s_q.frac[2] == tmr_pkg::FRAC_MAX)
    else $error("high reading not clamped");
  chk_ext_clamp_lo: assert property ( // RULE13
    (measValid[1] && extRange && measTemp[1][tmr_pkg::RAW_W-1]
    && !measTemp[1][tmr_pkg::RAW_W-2])
    |=> s_q.intB[1] == tmr_pkg::RST_BYTE
    && s_q.frac[1] == tmr_pkg::RST_FRAC)
    else $error("low offset reading not clamped");
  chk_ext_clamp_hi: assert property ( // RULE13
    (measValid[3] && extRange
    && measTemp[3][tmr_pkg::RAW_W-1 -: 3] == 3'h3)
    |=> s_q.intB[3] == tmr_pkg::EXT_MAX[7:0]
    && s_q.frac[3] == tmr_pkg::FRAC_MAX)
    else $error("high offset reading not clamped");

  // Status levels and sticky clear
  chk_hot_level: assert property ( // RULE8
    statusFlags[tmr_pkg::ST_HOT] == $past(hottestChanged))
    else $error("hottest flag wrong");
  chk_busy_level: assert property ( // RULE8
    statusFlags[tmr_pkg::ST_BUSY] == $past(convBusy))
    else $error("busy flag wrong");
  chk_sticky_clear: assert property ( // RULE11
    (statusRd && !highEvent && !lowEvent && !faultEvent)
    |=> !alertAct)
    else $error("alert kept after status read");

  cov_interlock: cover property (
    regRd && regAddr == tmr_pkg::INT_OFS_PRI[1] ##1 measValid[1]
    ##1 regRd && regAddr == tmr_pkg::FRAC_OFS_PRI[1]);
  cov_ext_range: cover property (measValid[4] && extRange);
  cov_unmapped: cover property (regRd && !dec.hit);

endmodule : tmr_result_regs

// *** tmr_pkg.sv ***
// Shared constants and types for the temperature result and status bank
package tmr_pkg;

  // Channel counts: index 0 is the internal diode, 1..4 the external ones
  localparam int NUM_CHAN      = 5;
  localparam int CHAN_IDX_W    = 3;
  localparam int RAW_W         = 12;
  localparam int FRAC_W        = 3;
  localparam int FRAC_LSB      = 5;
  localparam int FRAC_PAD_W    = 5;

  // Register offsets
  localparam logic [7:0] ADDR_STATUS = 8'h02;
  localparam logic [NUM_CHAN-1:0][7:0] INT_OFS_PRI =
    {8'h32, 8'h2a, 8'h23, 8'h01, 8'h00};
  localparam logic [NUM_CHAN-1:0][7:0] INT_OFS_MIR =
    {8'h68, 8'h66, 8'h64, 8'h62, 8'h60};
  localparam logic [NUM_CHAN-1:0][7:0] FRAC_OFS_PRI =
    {8'h33, 8'h2b, 8'h24, 8'h10, 8'h29};
  localparam logic [NUM_CHAN-1:0][7:0] FRAC_OFS_MIR =
    {8'h69, 8'h67, 8'h65, 8'h63, 8'h61};

  // Reset values
  localparam logic [7:0]        RST_BYTE   = 8'h00;
  localparam logic [FRAC_W-1:0] RST_FRAC   = 3'h0;
  localparam logic [7:0]        UNMAPPED   = 8'h00;

  // Status bit positions
  localparam int ST_ROC   = 7;
  localparam int ST_HOT   = 6;
  localparam int ST_BUSY  = 5;
  localparam int ST_HIGH  = 4;
  localparam int ST_LOW   = 3;
  localparam int ST_FAULT = 2;
  localparam int ST_ECRIT = 1;
  localparam int ST_ICRIT = 0;

  // Scale limits, in whole degrees, and the top fraction code in eighths
  localparam logic signed [9:0] EXT_OFFSET = 10'sd64;
  localparam logic signed [9:0] EXT_MAX    = 10'sd255;
  localparam logic signed [9:0] STD_MAX    = 10'sd127;
  localparam logic [FRAC_W-1:0] FRAC_MAX   = 3'h7;

  typedef struct packed {
    logic                  hit;
    logic                  isStatus;
    logic                  isFrac;
    logic [CHAN_IDX_W-1:0] chan;
  } tmr_decode_t;

  typedef struct packed {
    logic [7:0]        intByte;
    logic [FRAC_W-1:0] frac;
  } tmr_result_t;

  typedef struct packed {
    logic [NUM_CHAN-1:0][7:0]        intB;
    logic [NUM_CHAN-1:0][FRAC_W-1:0] frac;
    logic [NUM_CHAN-1:0][FRAC_W-1:0] shadow;
    logic [7:0]                      rdData;
    logic                            rdValid;
  } tmr_main_state_t;

  typedef struct packed {
    logic [7:0] flags;
    logic       critPrev;
  } tmr_stat_state_t;

endpackage : tmr_pkg

// *** tmr_temp_encoder.sv ***
// Converts a raw channel reading into integer byte and fraction code
`timescale 1ns/100ps
module tmr_temp_encoder (
  // Raw reading in eighths of a degree, two's complement
  input  wire logic signed [tmr_pkg::RAW_W-1:0] tempRaw,
  // Scale select
  input  wire logic                             extRange,
  // Encoded result
  output tmr_pkg::tmr_result_t                  result
);

  logic signed [9:0] whole;
  logic signed [9:0] shifted;

  always_comb
  begin
    whole   = 10'($signed(tempRaw[tmr_pkg::RAW_W-1:tmr_pkg::FRAC_W]));
    result  = '0;
    if (extRange)
    begin
      // Offset binary, -64 reads as zero
      shifted = whole + tmr_pkg::EXT_OFFSET;
      if (shifted < 10'sd0)
        result = '0;
      else if (shifted > tmr_pkg::EXT_MAX)
        result = {tmr_pkg::EXT_MAX[7:0], tmr_pkg::FRAC_MAX};
      else
        result = {shifted[7:0], tempRaw[tmr_pkg::FRAC_W-1:0]};
    end
    else
    begin
      // Plain binary, clamped to 0..127.875
      shifted = whole;
      if (whole < 10'sd0)
        result = '0;
      else if (whole > tmr_pkg::STD_MAX)
        result = {tmr_pkg::STD_MAX[7:0], tmr_pkg::FRAC_MAX};
      else
        result = {whole[7:0], tempRaw[tmr_pkg::FRAC_W-1:0]};
    end
  end

endmodule : tmr_temp_encoder

// *** tmr_status_flags.sv ***
// Diode status flags, alert and critical pin drive
`timescale 1ns/100ps
module tmr_status_flags (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst,
  // Condition inputs from the measurement side
  input  wire logic       rocExceeded,
  input  wire logic       hottestChanged,
  input  wire logic       convBusy,
  input  wire logic       highEvent,
  input  wire logic       lowEvent,
  input  wire logic       faultEvent,
  input  wire logic       extOverCrit,
  input  wire logic       intOverCrit,
  // Status read strobe
  input  wire logic       statusRd,
  // Flags and pins
  output logic [7:0]      flags,
  output logic            alertAct,
  output logic            critAct
);

  tmr_pkg::tmr_stat_state_t s_q;
  tmr_pkg::tmr_stat_state_t s_d;
  logic                     pinNow;
  logic                     pinRelease;

  assign pinNow     = extOverCrit | intOverCrit;
  assign pinRelease = s_q.critPrev & ~pinNow;

  always_comb
  begin
    s_d          = s_q;
    s_d.critPrev = pinNow;
    // RULE9 roc level flag
    s_d.flags[tmr_pkg::ST_ROC]  = rocExceeded;
    s_d.flags[tmr_pkg::ST_HOT]  = hottestChanged;
    s_d.flags[tmr_pkg::ST_BUSY] = convBusy;
    // Read clears sticky alert flags, set wins
    if (statusRd)
    begin
      s_d.flags[tmr_pkg::ST_HIGH]  = 1'b0;
      s_d.flags[tmr_pkg::ST_LOW]   = 1'b0;
      s_d.flags[tmr_pkg::ST_FAULT] = 1'b0;
    end
    if (highEvent)
      s_d.flags[tmr_pkg::ST_HIGH] = 1'b1;
    // RULE11 low at or below threshold
    if (lowEvent)
      s_d.flags[tmr_pkg::ST_LOW] = 1'b1;
    if (faultEvent)
      s_d.flags[tmr_pkg::ST_FAULT] = 1'b1;
    // RULE12 clear on pin release
    if (pinRelease)
    begin
      s_d.flags[tmr_pkg::ST_ECRIT] = 1'b0;
      s_d.flags[tmr_pkg::ST_ICRIT] = 1'b0;
    end
    if (extOverCrit)
      s_d.flags[tmr_pkg::ST_ECRIT] = 1'b1;
    if (intOverCrit)
      s_d.flags[tmr_pkg::ST_ICRIT] = 1'b1;
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign flags = s_q.flags;
  // RULE11 alert from flags
  assign alertAct = s_q.flags[tmr_pkg::ST_HIGH] | s_q.flags[tmr_pkg::ST_LOW]
                  | s_q.flags[tmr_pkg::ST_FAULT];
  // RULE12 critical pin from flags
  assign critAct = s_q.flags[tmr_pkg::ST_ECRIT]
                 | s_q.flags[tmr_pkg::ST_ICRIT];

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  chk_roc_level: assert property ( // RULE9
    flags[tmr_pkg::ST_ROC] == $past(rocExceeded))
    else $error("roc flag does not follow condition");
  chk_alert_set: assert property ( // RULE11
    (highEvent | lowEvent | faultEvent) |=> alertAct)
    else $error("alert not raised after event");
  chk_crit_clear: assert property ( // RULE12
    (critAct && !extOverCrit && !intOverCrit) ##1
    (!extOverCrit && !intOverCrit) |=> !critAct)
    else $error("critical flags not cleared on release");
  chk_crit_hold: assert property ( // RULE12
    (extOverCrit | intOverCrit) |=> critAct)
    else $error("critical pin not driven");
  cov_alert: cover property (lowEvent ##1 alertAct ##[1:5] statusRd);
  cov_crit: cover property (extOverCrit ##1 !extOverCrit ##2 !critAct);

endmodule : tmr_status_flags

// *** tmr_host_model.sv ***
// Host side model issuing register reads and writes
`timescale 1ns/100ps
module tmr_host_model (
  // Clock
  input  wire logic       ref_clk,
  // Register port
  output logic      [7:0] regAddr,
  output logic            regRd,
  output logic            regWr,
  output logic      [7:0] regWrData,
  input  wire logic [7:0] rdData,
  input  wire logic       rdValid
);
  initial
  begin
    regAddr = 8'h00;
    regRd = 1'b0;
    regWr = 1'b0;
    regWrData = 8'h00;
  end

  task automatic rd(input logic [7:0] a, output logic [7:0] d,
                    output logic v);
    @(posedge ref_clk);
    #1;
    regAddr = a;
    regRd = 1'b1;
    @(posedge ref_clk);
    #1;
    regRd = 1'b0;
    regAddr = ~a;
    d = rdData;
    v = rdValid;
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    #1;
    regAddr = a;
    regWrData = d;
    regWr = 1'b1;
    @(posedge ref_clk);
    #1;
    regWr = 1'b0;
    regWrData = ~d;
  endtask : wr

  task automatic rd2(input logic [7:0] a, input logic [7:0] b,
                     output logic [7:0] d1, output logic [7:0] d2);
    @(posedge ref_clk);
    #1;
    regAddr = a;
    regRd = 1'b1;
    @(posedge ref_clk);
    #1;
    d1 = rdData;
    regAddr = b;
    @(posedge ref_clk);
    #1;
    regRd = 1'b0;
    regAddr = ~b;
    d2 = rdData;
  endtask : rd2
endmodule : tmr_host_model

// *** tb_temp_result_status_regs.sv ***
// Self-checking bench for the result and status bank
`timescale 1ns/100ps
module tb_temp_result_status_regs;
  logic             ref_clk;
  logic             rst;
  logic [7:0]       regAddr;
  logic             regRd;
  logic             regWr;
  logic [7:0]       regWrData;
  logic [7:0]       rdData;
  logic             rdValid;
  logic             extRange;
  logic [4:0]       measValid;
  logic [4:0][11:0] measTemp;
  logic             rocExceeded;
  logic             hottestChanged;
  logic             convBusy;
  logic             highEvent;
  logic             lowEvent;
  logic             faultEvent;
  logic             extOverCrit;
  logic             intOverCrit;
  logic             alertAct;
  logic             critAct;
  int               mismatches;
  int               nCompared;

  tmr_result_regs tmr_result_regs_i (
    .ref_clk(ref_clk), .rst(rst), .regAddr(regAddr), .regRd(regRd),
    .regWr(regWr), .regWrData(regWrData), .rdData(rdData),
    .rdValid(rdValid), .extRange(extRange), .measValid(measValid),
    .measTemp(measTemp), .rocExceeded(rocExceeded),
    .hottestChanged(hottestChanged), .convBusy(convBusy),
    .highEvent(highEvent), .lowEvent(lowEvent), .faultEvent(faultEvent),
    .extOverCrit(extOverCrit), .intOverCrit(intOverCrit),
    .alertAct(alertAct), .critAct(critAct));

  tmr_host_model tmr_host_model_i (
    .ref_clk(ref_clk), .regAddr(regAddr), .regRd(regRd), .regWr(regWr),
    .regWrData(regWrData), .rdData(rdData), .rdValid(rdValid));

  initial
  begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    nCompared++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic give_verdict();
    $display("Compared %0d, mismatches %0d", nCompared, mismatches);
    if (mismatches == 0 && nCompared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : give_verdict

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : cyc

  // Read one register, answer due one cycle later
  task automatic rdChk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic       v;
    tmr_host_model_i.rd(a, d, v);
    check({7'h00, v}, 8'h01);
    check(d, e);
  endtask : rdChk

  task automatic meas(input int c, input logic [11:0] t, input logic x);
    @(posedge ref_clk);
    #1;
    extRange = x;
    measTemp[c] = t;
    measValid[c] = 1'b1;
    cyc(1);
    measValid = 5'h00;
    measTemp[c] = ~t;
    cyc(1);
  endtask : meas

  // Expected code: integer in [10:3], fraction in [2:0]
  function automatic logic [10:0] enc(input logic [11:0] r,
                                      input logic x);
    int v;
    int mx;
    mx = x ? 2047 : 1023;
    v = $signed(r) + (x ? 512 : 0);
    if (v < 0) v = 0;
    if (v > mx) v = mx;
    return v[10:0];
  endfunction : enc

  initial
  begin
    #(100 * 60000);
    mismatches++;
    give_verdict();
  end

  initial
  begin : mainSeq
    logic [11:0] corner [7];
    logic [11:0] raw;
    logic [10:0] e;
    int          c;
    logic [7:0]  d1;
    logic [7:0]  d2;
    corner = '{12'h800, 12'h7ff, 12'h000, 12'h3ff, 12'h400, 12'hdff,
               12'he00};
    {rst, extRange, measValid, measTemp} = {1'b1, 1'b0, 5'h00, 60'h0};
    {rocExceeded, hottestChanged, convBusy} = 3'b000;
    {highEvent, lowEvent, faultEvent, extOverCrit, intOverCrit} = 5'h00;
    mismatches = 0;
    nCompared = 0;
    void'($urandom(29279));
    cyc(3);
    rst = 1'b0;
    for (int i = 0; i < 5; i++)
    begin
      rdChk(tmr_pkg::INT_OFS_PRI[i], 8'h00);
      rdChk(tmr_pkg::FRAC_OFS_MIR[i], 8'h00);
    end
    rdChk(tmr_pkg::ADDR_STATUS, 8'h00);
    rdChk(8'h05, 8'h00);
    // Shadow empty, then latched, then stale until re-read
    meas(0, 12'h0a5, 1'b0);
    rdChk(tmr_pkg::FRAC_OFS_PRI[0], 8'h00);
    rdChk(tmr_pkg::INT_OFS_PRI[0], 8'h14);
    rdChk(tmr_pkg::FRAC_OFS_PRI[0], 8'ha0);
    meas(0, 12'h0a2, 1'b0);
    rdChk(tmr_pkg::FRAC_OFS_MIR[0], 8'ha0);
    rdChk(tmr_pkg::INT_OFS_MIR[0], 8'h14);
    rdChk(tmr_pkg::FRAC_OFS_PRI[0], 8'h40);
    tmr_host_model_i.wr(tmr_pkg::INT_OFS_PRI[0], 8'h5a);
    tmr_host_model_i.wr(tmr_pkg::FRAC_OFS_MIR[0], 8'hff);
    tmr_host_model_i.wr(tmr_pkg::ADDR_STATUS, 8'hff);
    rdChk(tmr_pkg::INT_OFS_PRI[0], 8'h14);
    rdChk(tmr_pkg::FRAC_OFS_PRI[0], 8'h40);
    rdChk(tmr_pkg::ADDR_STATUS, 8'h00);
    // Back-to-back reads
    tmr_host_model_i.rd2(tmr_pkg::INT_OFS_MIR[0], tmr_pkg::INT_OFS_PRI[0],
                         d1, d2);
    check(d1, 8'h14);
    check(d2, 8'h14);
    meas(2, 12'h1f3, 1'b0);
    e = enc(12'h1f3, 1'b0);
    tmr_host_model_i.rd2(tmr_pkg::INT_OFS_MIR[2], tmr_pkg::FRAC_OFS_PRI[2],
                         d1, d2);
    check(d1, e[10:3]);
    check(d2, {e[2:0], 5'h00});
    // Corner and random readings on every channel, both scales
    for (int i = 0; i < 40; i++)
    begin
      c = i % 5;
      raw = (i < 14) ? corner[i >> 1] : 12'($urandom);
      e = enc(raw, i[0]);
      meas(c, raw, i[0]);
      rdChk(i[1] ? tmr_pkg::INT_OFS_MIR[c] : tmr_pkg::INT_OFS_PRI[c],
            e[10:3]);
      rdChk(i[2] ? tmr_pkg::FRAC_OFS_MIR[c] : tmr_pkg::FRAC_OFS_PRI[c],
            {e[2:0], 5'h00});
    end
    // Live status levels
    for (int b = 0; b < 3; b++)
    begin
      {rocExceeded, hottestChanged, convBusy} = 3'b100 >> b;
      cyc(2);
      rdChk(tmr_pkg::ADDR_STATUS, 8'h80 >> b);
      {rocExceeded, hottestChanged, convBusy} = 3'b000;
      cyc(2);
      rdChk(tmr_pkg::ADDR_STATUS, 8'h00);
    end
    // Sticky alert flags, cleared by a status read
    for (int b = 0; b < 3; b++)
    begin
      {highEvent, lowEvent, faultEvent} = 3'b100 >> b;
      cyc(1);
      {highEvent, lowEvent, faultEvent} = 3'b000;
      cyc(1);
      check({7'h00, alertAct}, 8'h01);
      rdChk(tmr_pkg::ADDR_STATUS, 8'h10 >> b);
      check({7'h00, alertAct}, 8'h00);
      rdChk(tmr_pkg::ADDR_STATUS, 8'h00);
    end
    // Critical flags follow the pin
    for (int b = 0; b < 2; b++)
    begin
      {extOverCrit, intOverCrit} = 2'b10 >> b;
      cyc(2);
      check({7'h00, critAct}, 8'h01);
      rdChk(tmr_pkg::ADDR_STATUS, 8'h02 >> b);
      {extOverCrit, intOverCrit} = 2'b00;
      cyc(3);
      check({7'h00, critAct}, 8'h00);
      rdChk(tmr_pkg::ADDR_STATUS, 8'h00);
    end
    // Second reset in mid-run
    rst = 1'b1;
    cyc(2);
    rst = 1'b0;
    rdChk(tmr_pkg::INT_OFS_PRI[4], 8'h00);
    rdChk(tmr_pkg::FRAC_OFS_PRI[4], 8'h00);
    give_verdict();
  end
endmodule : tb_temp_result_status_regs
